// *** uart_hs_pkg.sv ***
// Overview of operation
// - Handshake on: start only while clear-to-send low.
// - A started frame runs to completion unless transmit init aborts it.
// - Transmit disable mid-frame: finish, keep pin control.
// - Handshake off: start as soon as data waits.
// - Request-to-send driven only with receive handshake enabled.
// - Drive low on receive enable, or after delay.
// - Drive high on valid start bit.
// - Drive high when receive disabled while idle.
// - Drive high when reception ends while disabled.
// - Drive high when receiver is initialised.
// - Four-bit delay, up to 120 bit-times, from stop middle.
// - Start bit during delay stops countdown, stays high.
// - Next stop bit restarts the full delay.
// - Address mode: MSB set means address, 8 or 9 bits.
// - MSB examined only on error-free characters.
// - Address byte: full flag, request, leave address mode.
// - Data byte: full flag but no request.
// - Error: no full flag; error flags and request.
// - Address mode suppresses overrun after first byte.
// - Unread address byte then new character: overrun.
// - First byte after enabling checks prior unread byte or status.
// - Full flag clears on low byte read or init.
// - Error-sum request on overrun, framing or parity error.
// - Three-sample majority at sixteen samples per bit.
package uart_hs_pkg;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0C;
  localparam logic [7:0] OFS_TX_LOW = 8'h10;
  localparam logic [7:0] OFS_TX_HIGH = 8'h14;
  localparam logic [7:0] OFS_RX_LOW = 8'h18;
  localparam logic [7:0] OFS_RX_HIGH = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_TX_INIT = 2;
  localparam int CTRL_RX_INIT = 3;
  localparam int CTRL_CTS_EN = 5;
  localparam int CTRL_RTS_EN = 6;
  localparam logic [7:0] CTRL_STORE_MASK = 8'h63;
  localparam int MODE_PAR_EN = 2;
  localparam int MODE_PAR_ODD = 3;
  localparam int MODE_ADDR_EN = 4;
  localparam logic [1:0] LEN_NINE = 2'h1;
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_TX_DONE = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_FRAMING = 3;
  localparam int ST_PARITY = 4;
  localparam int ST_ERR_SUM = 5;
  localparam int ST_RX_FULL = 6;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] SUB_START_CHECK = 4'h1;
  localparam logic [3:0] SUB_SMP_FIRST = 4'h7;
  localparam logic [3:0] SUB_SMP_MID = 4'h8;
  localparam logic [3:0] SUB_SMP_LAST = 4'h9;
  localparam logic [3:0] BITS_BASE = 4'h8;
  localparam int DELAY_STEP_SHIFT = 7;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [3:0] RST_DELAY = 4'h0;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] baud;
    logic [7:0] baud_cnt;
    logic [3:0] delay;
    logic [8:0] tx_buf;
    logic tx_empty;
    logic tx_done;
    logic tx_busy;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic tx_pin;
    logic tx_oe;
    rx_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_idx;
    logic [1:0] rx_smp;
    logic [10:0] rx_sh;
    logic [8:0] rx_buf;
    logic rx_full;
    logic overrun;
    logic framing;
    logic parity;
    logic err_sum;
    logic err_unread;
    logic amode_first;
    logic rts;
    logic rts_run;
    logic [10:0] rts_cnt;
    logic full_irq;
    logic err_irq;
    logic ack;
    logic [8:0] dat;
  } state_t;
endpackage

// *** uart_hs.sv ***
`timescale 1ns/1ps
module uart_hs import uart_hs_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic clear_to_send_in,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic serial_tx_oe,
  output logic request_to_send_out,
  output logic rx_full_irq,
  output logic error_sum_irq
);

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic [10:0] delay_ticks(input logic [3:0] dly);
    return {7'h00, dly} << DELAY_STEP_SHIFT;
  endfunction

  state_t s_q;
  state_t s_d;

  logic acc, wr, rd;
  logic wr_ctrl, rx_init_ev, tx_init_ev, rd_rx_low, rd_status;
  logic tick, nine, par_en, amode, maj, sample_pt;
  logic [3:0] last_idx;
  logic start_ev, done_ev, bad, good, msb, ovr;
  logic [8:0] rx_data;
  logic rx_par, tx_par, load_ok;
  logic [11:0] frame;

  // A request is served once, at the same edge at which ack rises.
  assign acc = wb_cyc & wb_stb & ~s_q.ack;
  assign wr = acc & wb_we & wb_sel[0];
  assign rd = acc & ~wb_we;
  assign wr_ctrl = wr & is_reg(wb_adr, OFS_CONTROL);
  assign rx_init_ev = wr_ctrl & wb_dat_w[CTRL_RX_INIT];
  assign tx_init_ev = wr_ctrl & wb_dat_w[CTRL_TX_INIT];
  assign rd_rx_low = rd & is_reg(wb_adr, OFS_RX_LOW);
  assign rd_status = rd & is_reg(wb_adr, OFS_STATUS);

  assign tick = s_q.baud_cnt == s_q.baud;
  assign nine = s_q.mode[1:0] == LEN_NINE;
  assign par_en = s_q.mode[MODE_PAR_EN];
  assign amode = s_q.mode[MODE_ADDR_EN];
  assign last_idx = BITS_BASE + {3'h0, nine} + {3'h0, par_en};

  assign maj = (s_q.rx_smp[1] & s_q.rx_smp[0]) | (s_q.rx_smp[1] & serial_rx_pin)
             | (s_q.rx_smp[0] & serial_rx_pin);
  assign sample_pt = tick & (s_q.rx_sub == SUB_SMP_LAST);
  assign start_ev = (s_q.rx_state == RX_START) & sample_pt & ~maj;
  assign done_ev = (s_q.rx_state == RX_BITS) & sample_pt & (s_q.rx_idx == last_idx);

  assign rx_data = nine ? s_q.rx_sh[8:0] : {1'b0, s_q.rx_sh[7:0]};
  assign msb = nine ? s_q.rx_sh[8] : s_q.rx_sh[7];
  assign rx_par = nine ? s_q.rx_sh[9] : s_q.rx_sh[8];
  assign bad = ~maj | (par_en & (^rx_data ^ rx_par ^ s_q.mode[MODE_PAR_ODD]));
  assign good = done_ev & ~bad;

  // first byte only in address mode
  assign ovr = amode ? (s_q.amode_first & (s_q.rx_full | s_q.err_unread)) : s_q.rx_full;

  assign load_ok = ~s_q.tx_busy & s_q.ctrl[CTRL_TX_EN] & ~s_q.tx_empty
                 & (~s_q.ctrl[CTRL_CTS_EN] | ~clear_to_send_in);
  assign tx_par = par_en ? (^s_q.tx_buf[7:0] ^ (nine & s_q.tx_buf[8]) ^ s_q.mode[MODE_PAR_ODD])
                         : 1'b1;
  assign frame = nine ? {1'b1, tx_par, s_q.tx_buf, 1'b0}
                      : {2'b11, tx_par, s_q.tx_buf[7:0], 1'b0};

  always_comb begin
    s_d = s_q;
    s_d.ack = acc;
    s_d.dat = 9'h000;
    s_d.full_irq = 1'b0;
    s_d.err_irq = 1'b0;
    s_d.baud_cnt = tick ? 8'h00 : s_q.baud_cnt + 8'h01;

    if (rd) begin
      if (is_reg(wb_adr, OFS_CONTROL)) begin
        s_d.dat = {1'b0, s_q.ctrl};
      end else if (is_reg(wb_adr, OFS_MODE)) begin
        s_d.dat = {1'b0, s_q.mode};
      end else if (is_reg(wb_adr, OFS_BAUD)) begin
        s_d.dat = {1'b0, s_q.baud};
      end else if (is_reg(wb_adr, OFS_DELAY)) begin
        s_d.dat = {5'h00, s_q.delay};
      end else if (is_reg(wb_adr, OFS_RX_LOW)) begin
        s_d.dat = {1'b0, s_q.rx_buf[7:0]};
      end else if (is_reg(wb_adr, OFS_RX_HIGH)) begin
        s_d.dat = {8'h00, s_q.rx_buf[8]};
      end else if (is_reg(wb_adr, OFS_STATUS)) begin
        s_d.dat = {2'b00, s_q.rx_full, s_q.err_sum, s_q.parity, s_q.framing,
                   s_q.overrun, s_q.tx_done, s_q.tx_empty};
      end
    end
    if (rd_rx_low) begin
      s_d.rx_full = 1'b0;
    end
    if (rd_status) begin
      s_d.overrun = 1'b0;
      s_d.framing = 1'b0;
      s_d.parity = 1'b0;
      s_d.err_sum = 1'b0;
      s_d.err_unread = 1'b0;
    end

    // Transmitter.
    if (load_ok) begin
      s_d.tx_busy = 1'b1;
      s_d.tx_empty = 1'b1;
      s_d.tx_done = 1'b0;
      s_d.tx_sh = frame;
      s_d.tx_pin = 1'b0;
      s_d.tx_left = last_idx + 4'h1;
      s_d.tx_sub = 4'h0;
    end else if (s_q.tx_busy && tick) begin
      s_d.tx_sub = s_q.tx_sub + 4'h1;
      if (s_q.tx_sub == SUB_LAST) begin
        // ends only after the stop bit
        if (s_q.tx_left == 4'h0) begin
          s_d.tx_busy = 1'b0;
          s_d.tx_pin = 1'b1;
          s_d.tx_done = ~(s_q.ctrl[CTRL_TX_EN] & ~s_q.tx_empty
                          & (~s_q.ctrl[CTRL_CTS_EN] | ~clear_to_send_in));
        end else begin
          s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]};
          s_d.tx_pin = s_q.tx_sh[1];
          s_d.tx_left = s_q.tx_left - 4'h1;
        end
      end
    end
    if (wr && is_reg(wb_adr, OFS_TX_LOW)) begin
      s_d.tx_buf[7:0] = wb_dat_w[7:0];
      s_d.tx_empty = 1'b0;
    end
    if (wr && is_reg(wb_adr, OFS_TX_HIGH)) begin
      s_d.tx_buf[8] = wb_dat_w[0];
    end
    if (tx_init_ev) begin
      s_d.tx_busy = 1'b0;
      s_d.tx_pin = 1'b1;
      s_d.tx_empty = 1'b1;
      s_d.tx_done = 1'b1;
    end

    // Configuration writes; hardware clearing of address mode comes later and wins.
    if (wr_ctrl) begin
      s_d.ctrl = wb_dat_w[7:0] & CTRL_STORE_MASK;
    end
    if (wr && is_reg(wb_adr, OFS_MODE)) begin
      s_d.mode = wb_dat_w[7:0];
      if (wb_dat_w[MODE_ADDR_EN] && !amode) begin
        s_d.amode_first = 1'b1;
      end
    end
    if (wr && is_reg(wb_adr, OFS_BAUD)) begin
      s_d.baud = wb_dat_w[7:0];
    end
    if (wr && is_reg(wb_adr, OFS_DELAY)) begin
      s_d.delay = wb_dat_w[3:0];
    end

    if ((s_q.rx_state != RX_IDLE) && tick) begin
      s_d.rx_sub = s_q.rx_sub + 4'h1;
      if (s_q.rx_sub == SUB_SMP_FIRST || s_q.rx_sub == SUB_SMP_MID) begin
        s_d.rx_smp = {s_q.rx_smp[0], serial_rx_pin};
      end
    end
    unique case (s_q.rx_state)
      RX_IDLE: begin
        if (tick && !serial_rx_pin && s_q.ctrl[CTRL_RX_EN]) begin
          s_d.rx_state = RX_START;
          s_d.rx_sub = 4'h0;
        end
      end
      RX_START: begin
        if (tick && s_q.rx_sub == SUB_START_CHECK && serial_rx_pin) begin
          s_d.rx_state = RX_IDLE;
        end else if (sample_pt) begin
          s_d.rx_state = maj ? RX_IDLE : RX_BITS;
          s_d.rx_idx = 4'h0;
        end
      end
      RX_BITS: begin
        if (sample_pt) begin
          s_d.rx_sh[s_q.rx_idx] = maj;
          s_d.rx_idx = s_q.rx_idx + 4'h1;
          if (done_ev) begin
            s_d.rx_state = RX_IDLE;
          end
        end
      end
      default: s_d.rx_state = RX_IDLE;
    endcase

    if (done_ev) begin
      if (amode) begin
        s_d.amode_first = 1'b0;
      end
      // overrun after address byte left unread
      if (ovr) begin
        s_d.overrun = 1'b1;
        s_d.err_sum = 1'b1;
        s_d.err_irq = 1'b1;
      end
      if (bad) begin
        s_d.framing = s_q.framing | ~maj;
        s_d.parity = s_q.parity | (maj & par_en);
        s_d.err_sum = 1'b1;
        s_d.err_unread = 1'b1;
        s_d.err_irq = 1'b1;
      end else begin
        s_d.rx_buf = rx_data;
        s_d.rx_full = 1'b1;
        // data byte silent in address mode
        s_d.full_irq = ~amode | msb;
        if (amode && msb) begin
          s_d.mode[MODE_ADDR_EN] = 1'b0;
        end
      end
    end

    if (s_q.rts_run && tick) begin
      s_d.rts_cnt = s_q.rts_cnt - 11'h001;
      if (s_q.rts_cnt == 11'h001) begin
        s_d.rts = 1'b0;
        s_d.rts_run = 1'b0;
      end
    end
    if (done_ev) begin
      if (s_q.ctrl[CTRL_RX_EN]) begin
        s_d.rts_cnt = delay_ticks(s_q.delay);
        s_d.rts_run = s_q.delay != 4'h0;
        s_d.rts = s_q.delay != 4'h0;
      end else begin
        s_d.rts = 1'b1;
      end
    end
    if (start_ev && s_q.ctrl[CTRL_RX_EN]) begin
      s_d.rts = 1'b1;
      s_d.rts_run = 1'b0;
    end
    if (wr_ctrl) begin
      if (wb_dat_w[CTRL_RX_EN] && !(s_q.ctrl[CTRL_RX_EN] && s_q.ctrl[CTRL_RTS_EN])) begin
        s_d.rts = 1'b0;
        s_d.rts_run = 1'b0;
      end
      if (!wb_dat_w[CTRL_RX_EN] && s_q.ctrl[CTRL_RX_EN] && s_q.rx_state == RX_IDLE) begin
        s_d.rts = 1'b1;
        s_d.rts_run = 1'b0;
      end
    end
    // init forces high and clears receive state
    if (rx_init_ev) begin
      s_d.rts = 1'b1;
      s_d.rts_run = 1'b0;
      s_d.rx_state = RX_IDLE;
      s_d.rx_full = 1'b0;
      s_d.overrun = 1'b0;
      s_d.framing = 1'b0;
      s_d.parity = 1'b0;
      s_d.err_sum = 1'b0;
      s_d.err_unread = 1'b0;
    end
    if (!s_d.ctrl[CTRL_RTS_EN]) begin
      s_d.rts = 1'b1;
      s_d.rts_run = 1'b0;
    end
    // pins stay owned until the frame ends
    s_d.tx_oe = s_d.ctrl[CTRL_TX_EN] | s_d.tx_busy;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ctrl <= RST_CTRL;
      s_q.mode <= RST_MODE;
      s_q.baud <= RST_BAUD;
      s_q.delay <= RST_DELAY;
      s_q.tx_empty <= 1'b1;
      s_q.tx_done <= 1'b1;
      s_q.tx_pin <= 1'b1;
      s_q.rx_state <= RX_IDLE;
      s_q.rts <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack = s_q.ack;
  assign wb_dat_r = {23'h000000, s_q.dat};
  assign serial_tx_pin = s_q.tx_pin;
  assign serial_tx_oe = s_q.tx_oe;
  assign request_to_send_out = s_q.rts;
  assign rx_full_irq = s_q.full_irq;
  assign error_sum_irq = s_q.err_irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  a_cts_gate_start: assert property (
    ($rose(s_q.tx_busy) && $past(s_q.ctrl[CTRL_CTS_EN])) |-> $past(!clear_to_send_in))
    else $error("Frame started while clear-to-send was high.");
  a_tx_full_frame: assert property (
    ($fell(s_q.tx_busy) && !$past(tx_init_ev))
      |-> ($past(s_q.tx_left) == 4'h0 && $past(s_q.tx_sub) == SUB_LAST && serial_tx_pin))
    else $error("Frame ended before its stop bit.");
  a_tx_pins_kept: assert property (
    s_q.tx_busy |-> serial_tx_oe)
    else $error("Transmit pin released during a frame.");
  a_tx_free_start: assert property (
    (load_ok && !s_q.ctrl[CTRL_CTS_EN] && !tx_init_ev) |=> (s_q.tx_busy && !serial_tx_pin))
    else $error("Frame did not start with handshake off.");
  a_rts_disabled_high: assert property (
    !s_q.ctrl[CTRL_RTS_EN] |-> request_to_send_out)
    else $error("Request-to-send low with handshake off.");
  a_rts_start_high: assert property (
    (start_ev && s_q.ctrl[CTRL_RX_EN] && !wr_ctrl) |=> (request_to_send_out && !s_q.rts_run))
    else $error("Request-to-send not high after start bit.");
  a_rts_init_high: assert property (
    rx_init_ev |=> (request_to_send_out && !s_q.rx_full))
    else $error("Receiver init did not raise request-to-send.");
  a_rts_delay_load: assert property (
    (done_ev && s_q.ctrl[CTRL_RX_EN] && s_q.ctrl[CTRL_RTS_EN] && !wr_ctrl && s_q.delay != 4'h0)
      |=> (s_q.rts_run && request_to_send_out && s_q.rts_cnt == delay_ticks($past(s_q.delay))))
    else $error("Delay countdown not loaded at stop middle.");
  a_addr_wakeup: assert property (
    (good && amode && msb) |=> (!s_q.mode[MODE_ADDR_EN] && s_q.full_irq && rx_full_irq))
    else $error("Address byte did not end address mode.");
  a_data_silent: assert property (
    (good && amode && !msb && !rx_init_ev) |=> (s_q.rx_full && !rx_full_irq))
    else $error("Data byte raised a request in address mode.");
  a_err_no_full: assert property (
    (done_ev && bad && !s_q.rx_full && !rx_init_ev)
      |=> (!s_q.rx_full && s_q.err_sum && error_sum_irq && !rx_full_irq))
    else $error("Errored character handled as good.");
  a_amode_no_ovr: assert property (
    (done_ev && amode && !s_q.amode_first && !s_q.overrun) |=> !s_q.overrun)
    else $error("Overrun raised inside address mode.");
  a_full_read_clr: assert property (
    (rd_rx_low && !done_ev) |=> !s_q.rx_full)
    else $error("Low byte read did not clear full flag.");
endmodule

// *** remote_link.sv ***
`timescale 1ns/1ps
module remote_link (
  input wire logic sys_clk,
  input wire logic serial_tx_pin,
  output logic serial_rx_pin,
  output logic clear_to_send_in
);
  localparam int BIT_CLKS = 16;
  logic [7:0] seen_q[$];
  logic [7:0] shift;
  initial begin
    serial_rx_pin = 1'b1;
    clear_to_send_in = 1'b1;
  end
  task automatic send_frame(input logic [11:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge sys_clk);
      serial_rx_pin <= f[i];
      repeat (BIT_CLKS - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    serial_rx_pin <= 1'b1;
  endtask
  task automatic send_char(input logic [7:0] c, input logic stop);
    send_frame({2'b11, stop, c, 1'b0}, 10);
  endtask
  task automatic set_cts(input logic v);
    @(posedge sys_clk);
    clear_to_send_in <= v;
  endtask
  // Sampling on the falling edge keeps clear of the pin's own update edge.
  always begin
    @(negedge sys_clk);
    if (serial_tx_pin === 1'b0) begin
      repeat (BIT_CLKS + BIT_CLKS / 2) @(negedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        shift[i] = serial_tx_pin;
        repeat (BIT_CLKS) @(negedge sys_clk);
      end
      seen_q.push_back(shift);
      repeat (BIT_CLKS / 2) @(negedge sys_clk);
    end
  end
endmodule

// *** uart_handshake_address_mode_test.sv ***
`timescale 1ns/1ps
module uart_handshake_address_mode_test;
  import uart_hs_pkg::*;
  logic sys_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic clear_to_send_in, serial_rx_pin, serial_tx_pin, serial_tx_oe;
  logic request_to_send_out, rx_full_irq, error_sum_irq;
  int err_total = 0, samples_checked = 0, full_seen = 0, err_seen = 0, exp_full = 0;
  int exp_err = 0;
  logic [7:0] b;
  logic [7:0] tx_model[$];
  logic [7:0] ctl_v [5] = '{8'h42, 8'h40, 8'h42, 8'h4A, 8'h02};
  logic rts_v [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  uart_hs i_uart_hs (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .clear_to_send_in(clear_to_send_in), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .serial_tx_oe(serial_tx_oe),
    .request_to_send_out(request_to_send_out), .rx_full_irq(rx_full_irq),
    .error_sum_irq(error_sum_irq));
  remote_link i_remote_link (.sys_clk(sys_clk), .serial_tx_pin(serial_tx_pin),
    .serial_rx_pin(serial_rx_pin), .clear_to_send_in(clear_to_send_in));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (rx_full_irq === 1'b1) full_seen <= full_seen + 1;
    if (error_sum_irq === 1'b1) err_seen <= err_seen + 1;
  end
  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_up();
    err_total++;
    $display("MISMATCH at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= 4'hF;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) give_up();
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb_cycle(a, 1'b1, {24'h000000, d});
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] want);
    wb_cycle(a, 1'b0, 32'h00000000);
    check(rd, {24'h000000, want});
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wait_tx();
    int n;
    n = 0;
    while (i_remote_link.seen_q.size() == 0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) give_up();
    check(i_remote_link.seen_q.pop_front(), tx_model.pop_front());
  endtask
  task automatic send(input logic [7:0] c, input logic stop);
    i_remote_link.send_char(c, stop);
    clks(4);
  endtask
  // Nine data bits with parity; flip makes the parity wrong on purpose.
  task automatic send9(input logic [8:0] d, input logic odd, input logic flip);
    i_remote_link.send_frame({1'b1, (^d ^ odd ^ flip), d, 1'b0}, 12);
    clks(4);
  endtask
  initial begin
    int n;
    sys_rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h00000000;
    void'($urandom(32'hB1F94471));
    clks(8);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd_check(OFS_STATUS, 8'h03);
    rd_check(8'hFC, 8'h00);
    wr(OFS_BAUD, 8'h00);
    b = 8'($urandom);
    tx_model.push_back(b);
    wr(OFS_CONTROL, 8'h01);
    wr(OFS_TX_LOW, b);
    wait_tx();
    b = 8'($urandom);
    tx_model.push_back(b);
    wr(OFS_CONTROL, 8'h21);
    wr(OFS_TX_LOW, b);
    clks(200);
    check(serial_tx_pin, 1'b1);
    check(i_remote_link.seen_q.size(), 0);
    i_remote_link.set_cts(1'b0);
    n = 0;
    while (serial_tx_pin !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 100) give_up();
    // Withdrawing both permission and enable mid-frame must not cut it short.
    i_remote_link.set_cts(1'b1);
    wr(OFS_CONTROL, 8'h20);
    check(serial_tx_oe, 1'b1);
    wait_tx();
    clks(40);
    check(serial_tx_oe, 1'b0);
    wr(OFS_TX_LOW, 8'h5A);
    clks(20);
    check(serial_tx_pin, 1'b1);
    rd_check(OFS_STATUS, 8'h02);
    wr(OFS_CONTROL, 8'h04);
    rd_check(OFS_STATUS, 8'h03);
    wr(OFS_DELAY, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CONTROL, ctl_v[i]);
      clks(3);
      check(request_to_send_out, rts_v[i]);
    end
    wr(OFS_CONTROL, 8'h42);
    clks(3);
    b = 8'($urandom);
    fork
      i_remote_link.send_char(b, 1'b1);
      begin
        clks(60);
        check(request_to_send_out, 1'b1);
      end
    join
    clks(4);
    check(request_to_send_out, 1'b0);
    rd_check(OFS_STATUS, 8'h43);
    rd_check(OFS_RX_LOW, b);
    rd_check(OFS_STATUS, 8'h03);
    wr(OFS_DELAY, 8'h01);
    send(8'($urandom), 1'b1);
    clks(46);
    check(request_to_send_out, 1'b1);
    clks(100);
    check(request_to_send_out, 1'b0);
    wr(OFS_DELAY, 8'h04);
    i_remote_link.send_char(8'($urandom), 1'b1);
    clks(30);
    i_remote_link.send_char(8'($urandom), 1'b1);
    clks(490);
    check(request_to_send_out, 1'b1);
    clks(50);
    check(request_to_send_out, 1'b0);
    wr(OFS_DELAY, 8'h00);
    fork
      i_remote_link.send_char(8'($urandom), 1'b1);
      begin
        clks(60);
        wr(OFS_CONTROL, 8'h40);
      end
    join
    clks(4);
    check(request_to_send_out, 1'b1);
    wr(OFS_CONTROL, 8'h02);
    wb_cycle(OFS_RX_LOW, 1'b0, 32'h00000000);
    wb_cycle(OFS_STATUS, 1'b0, 32'h00000000);
    exp_full = full_seen;
    exp_err = err_seen;
    wr(OFS_MODE, 8'h10);
    send(8'h35, 1'b1);
    check(full_seen, exp_full);
    rd_check(OFS_STATUS, 8'h43);
    send(8'h36, 1'b1);
    rd_check(OFS_STATUS, 8'h43);
    rd_check(OFS_RX_LOW, 8'h36);
    send(8'h80, 1'b0);
    exp_err++;
    check(err_seen, exp_err);
    send(8'h37, 1'b1);
    check(full_seen, exp_full);
    rd_check(OFS_STATUS, 8'h6B);
    rd_check(OFS_RX_LOW, 8'h37);
    send(8'hA5, 1'b1);
    exp_full++;
    check(full_seen, exp_full);
    rd_check(OFS_MODE, 8'h00);
    send(8'h11, 1'b1);
    exp_err++;
    exp_full++;
    check(err_seen, exp_err);
    check(full_seen, exp_full);
    rd_check(OFS_STATUS, 8'h67);
    wr(OFS_MODE, 8'h10);
    send(8'h22, 1'b1);
    exp_err++;
    check(err_seen, exp_err);
    rd_check(OFS_STATUS, 8'h67);
    wb_cycle(OFS_RX_LOW, 1'b0, 32'h00000000);
    wb_cycle(OFS_STATUS, 1'b0, 32'h00000000);
    wr(OFS_MODE, 8'h15);
    send9(9'h0A5, 1'b0, 1'b0);
    check(full_seen, exp_full);
    rd_check(OFS_MODE, 8'h15);
    rd_check(OFS_RX_HIGH, 8'h00);
    rd_check(OFS_RX_LOW, 8'hA5);
    send9(9'h1C3, 1'b0, 1'b1);
    exp_err++;
    check(err_seen, exp_err);
    check(full_seen, exp_full);
    rd_check(OFS_STATUS, 8'h33);
    rd_check(OFS_MODE, 8'h15);
    wr(OFS_MODE, 8'h1D);
    send9(9'h1C3, 1'b1, 1'b0);
    exp_full++;
    check(full_seen, exp_full);
    rd_check(OFS_MODE, 8'h0D);
    rd_check(OFS_RX_HIGH, 8'h01);
    rd_check(OFS_RX_LOW, 8'hC3);
    tally_and_finish();
  end
endmodule
